// [rtc_trim_regs.svh]
`ifndef RTC_TRIM_REGS_SVH
`define RTC_TRIM_REGS_SVH

// Trim register layout and reset value
`define TRIM_WIDTH 8
`define TRIM_RESET 8'h00
`define TRIM_RES_BIT 0
`define TRIM_STEPS_LSB 1
`define TRIM_STEPS_MSB 7

// Oscillator and divider chain
`define OSC_HZ 32768
`define OSC_COUNT_W 16
`define OSC_SUB_ZERO 16'h0000
`define OSC_SUB_ONE 16'h0001

// Correction interval lengths in seconds
`define SEC_W 6
`define SEC_ZERO 6'h00
`define SEC_ONE 6'h01
`define INTERVAL_COARSE 6'h14
`define INTERVAL_FINE 6'h3c

// Serial framing
`define BIT_CNT_W 4
`define BIT_CNT_ZERO 4'h0
`define BIT_CNT_ONE 4'h1
`define BITS_PER_BYTE 4'h8
`define LINE_IDLE 1'b1
`define LINE_LOW 1'b0

`endif

// [rtc_trim_pkg.sv]
package rtc_trim_pkg;

    // Serial receiver states
    typedef enum logic [1:0] {SER_IDLE, SER_DATA, SER_ACK} serial_state_type;

endpackage

// [byte_link_if.sv]
`timescale 1ns/10ps
interface byte_link_if;
    logic [7:0] data;
    logic valid;
    logic ready;

    // Receiver side offers bytes
    modport rx (output data, output valid, input ready);
    // Core side takes them
    modport core (input data, input valid, output ready);
endinterface

// [two_wire_byte_rx.sv]
`timescale 1ns/10ps
`include "rtc_trim_regs.svh"
module two_wire_byte_rx (
    // System
    input wire logic clk,
    input wire logic rst,
    // Bus pins, sda open drain
    input wire logic scl,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    // Received bytes
    byte_link_if.rx link
);

    logic [1:0] sclSync_reg;
    logic [1:0] sdaSync_reg;
    logic sclPrev_reg;
    logic sdaPrev_reg;
    logic sclNow;
    logic sdaNow;
    logic sclRise;
    logic sclFall;
    logic startSeen;
    logic stopSeen;
    logic byteDone;
    rtc_trim_pkg::serial_state_type state_reg;
    logic [`BIT_CNT_W-1:0] bitCnt_reg;
    logic [7:0] shift_reg;
    logic [7:0] data_reg;
    logic valid_reg;
    logic ackDrive_reg;

    // Pins come from another domain: two stages, then a history stage
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            sclSync_reg <= {2{`LINE_IDLE}};
            sdaSync_reg <= {2{`LINE_IDLE}};
            sclPrev_reg <= `LINE_IDLE;
            sdaPrev_reg <= `LINE_IDLE;
        end
        else
        begin
            sclSync_reg <= {sclSync_reg[0], scl};
            sdaSync_reg <= {sdaSync_reg[0], sdaIn};
            sclPrev_reg <= sclSync_reg[1];
            sdaPrev_reg <= sdaSync_reg[1];
        end
    end

    // Line events, only from settled samples
    assign sclNow = sclSync_reg[1];
    assign sdaNow = sdaSync_reg[1];
    assign sclRise = sclNow && !sclPrev_reg;
    assign sclFall = !sclNow && sclPrev_reg;
    assign startSeen = sclNow && sclPrev_reg && sdaPrev_reg && !sdaNow;
    assign stopSeen = sclNow && sclPrev_reg && !sdaPrev_reg && sdaNow;
    assign byteDone = (state_reg == rtc_trim_pkg::SER_DATA) && sclFall
        && (bitCnt_reg == `BITS_PER_BYTE);

    // Framing; a condition mid-byte aborts the byte
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state_reg <= rtc_trim_pkg::SER_IDLE;
            bitCnt_reg <= `BIT_CNT_ZERO;
        end
        else if (startSeen)
        begin
            state_reg <= rtc_trim_pkg::SER_DATA;
            bitCnt_reg <= `BIT_CNT_ZERO;
        end
        else if (stopSeen)
        begin
            state_reg <= rtc_trim_pkg::SER_IDLE;
            bitCnt_reg <= `BIT_CNT_ZERO;
        end
        else
        begin
            case (state_reg)
                rtc_trim_pkg::SER_DATA:
                begin
                    if (byteDone)
                        state_reg <= rtc_trim_pkg::SER_ACK;
                    else if (sclRise)
                        bitCnt_reg <= bitCnt_reg + `BIT_CNT_ONE;
                end
                rtc_trim_pkg::SER_ACK:
                begin
                    if (sclFall)
                    begin
                        state_reg <= rtc_trim_pkg::SER_DATA;
                        bitCnt_reg <= `BIT_CNT_ZERO;
                    end
                end
                default:
                    bitCnt_reg <= `BIT_CNT_ZERO;
            endcase
        end
    end

    // Data bits are sampled on rising scl only, whole bytes
    always_ff @(posedge clk)
    begin
        if (rst)
            shift_reg <= `TRIM_RESET;
        else if (state_reg == rtc_trim_pkg::SER_DATA && sclRise && !startSeen)
            shift_reg <= {shift_reg[6:0], sdaNow};
    end

    // Acknowledge only when the core can take the byte
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            ackDrive_reg <= 1'b0;
            valid_reg <= 1'b0;
            data_reg <= `TRIM_RESET;
        end
        else
        begin
            valid_reg <= byteDone && link.ready;
            if (byteDone && link.ready)
                data_reg <= shift_reg;
            if (byteDone)
                ackDrive_reg <= link.ready;
            else if (sclFall || startSeen || stopSeen)
                ackDrive_reg <= 1'b0;
        end
    end

    assign sdaOut = `LINE_LOW;
    assign sdaOe = ackDrive_reg;
    assign link.data = data_reg;
    assign link.valid = valid_reg;

    sequence ninthClockDue;
        byteDone && link.ready;
    endsequence

    sequence ninthClockRefused;
        byteDone && !link.ready;
    endsequence

    a_ack_drive: assert property (@(posedge clk) disable iff (rst)
        ninthClockDue |=> sdaOe && valid_reg)
        else $error("ack not driven on ninth clock");
    a_ack_withheld: assert property (@(posedge clk) disable iff (rst)
        ninthClockRefused |=> !sdaOe && !valid_reg)
        else $error("ack given while core busy");
    a_ack_release: assert property (@(posedge clk) disable iff (rst)
        (sdaOe && sclFall) |=> !sdaOe ##1 (state_reg == rtc_trim_pkg::SER_DATA
        || state_reg == rtc_trim_pkg::SER_IDLE))
        else $error("ack held past ninth clock");
    a_stop_standby: assert property (@(posedge clk) disable iff (rst)
        stopSeen |=> state_reg == rtc_trim_pkg::SER_IDLE && !sdaOe)
        else $error("stop did not end access");
    a_start_restart: assert property (@(posedge clk) disable iff (rst)
        startSeen |=> state_reg == rtc_trim_pkg::SER_DATA && bitCnt_reg == `BIT_CNT_ZERO)
        else $error("start did not restart byte");

endmodule

// [rtc_clock_rate_correction.sv]
// Behaviour
// - Trim bit zero picks step size, about 3.052 or 1.017 ppm.
// - Bits seven to one hold reversed signed step count; zero means none.
// - Oscillator is never trimmed; only the derived time base changes.
// - One 1 Hz period in every 20 or 60 is altered.
// - SDA falling while SCL high starts an access.
// - SDA rising while SCL high ends the access, back to standby.
// - Data moves in whole bytes; transmitter changes SDA while SCL low.
// - SDA change with SCL high mid-byte aborts the ongoing access.
// - Master releases SDA after eighth fall; device pulls low on ninth.
// - Acknowledge is withheld when the access is not regular.
// - Correction applied once per 20 s, or per 60 s with bit zero set.
// - Correction adjusts pulses in the divider chain.
`timescale 1ns/10ps
`include "rtc_trim_regs.svh"
module rtc_clock_rate_correction #(
    parameter int unsigned OSC_DIV = `OSC_HZ
) (
    // System clock and reset
    input wire logic clk,
    input wire logic rst,
    // Crystal oscillator clock
    input wire logic oscClk,
    // Two-wire bus, sda open drain
    input wire logic scl,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    // Status
    output logic [`TRIM_WIDTH-1:0] trimValue,
    output logic correctionOn,
    output logic tick1Hz
);

    localparam logic [`OSC_COUNT_W-1:0] DIV_CYCLES = `OSC_COUNT_W'(OSC_DIV);
    localparam logic [`OSC_COUNT_W-1:0] HALF_CYCLES = DIV_CYCLES >> 1;

    // Reversed signed step count, bit one is the sign
    function automatic logic [6:0] decodeSteps(input logic [`TRIM_WIDTH-1:0] t);
        logic [6:0] s;
        s = '0;
        for (int i = 0; i < 7; i++)
            s[6-i] = t[`TRIM_STEPS_LSB+i];
        return s;
    endfunction

    byte_link_if link ();

    two_wire_byte_rx rxUnit (
        .clk(clk),
        .rst(rst),
        .scl(scl),
        .sdaIn(sdaIn),
        .sdaOut(sdaOut),
        .sdaOe(sdaOe),
        .link(link)
    );

    // ---- System clock domain ----
    logic [`TRIM_WIDTH-1:0] trim_reg;
    logic reqTgl_reg;
    logic [1:0] ackSync_reg;
    logic [1:0] onSync_reg;
    logic busy;

    // Writes are blocked until the oscillator side took the last one
    assign busy = reqTgl_reg != ackSync_reg[1];
    assign link.ready = !busy;

    // Trim register; the held value is what crosses domains
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            trim_reg <= `TRIM_RESET;
            reqTgl_reg <= 1'b0;
        end
        else if (link.valid)
        begin
            trim_reg <= link.data;
            reqTgl_reg <= ~reqTgl_reg;
        end
    end

    logic ackTgl_reg;
    logic corrActive_reg;

    // Returns from the oscillator domain
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            ackSync_reg <= 2'h0;
            onSync_reg <= 2'h0;
        end
        else
        begin
            ackSync_reg <= {ackSync_reg[0], ackTgl_reg};
            onSync_reg <= {onSync_reg[0], corrActive_reg};
        end
    end

    assign trimValue = trim_reg;
    assign correctionOn = onSync_reg[1];

    // ---- Oscillator domain ----
    logic [1:0] rstSync_reg;
    logic rstOsc;
    logic [2:0] reqSync_reg;
    logic newReq;
    logic [`TRIM_WIDTH-1:0] pendTrim_reg;
    logic [`TRIM_WIDTH-1:0] activeTrim_reg;
    logic [`OSC_COUNT_W-1:0] subCnt_reg;
    logic [`SEC_W-1:0] secCnt_reg;
    logic tick_reg;
    logic [6:0] steps;
    logic [`OSC_COUNT_W-1:0] adjust;
    logic [`OSC_COUNT_W-1:0] periodLen;
    logic [`SEC_W-1:0] intervalLen;
    logic corrSecond;
    logic secondEnd;
    logic boundary;

    // Reset reaches this domain through two stages
    always_ff @(posedge oscClk)
    begin
        rstSync_reg <= {rstSync_reg[0], rst};
    end
    assign rstOsc = rstSync_reg[1];

    // Request toggle: two stages then a history stage
    always_ff @(posedge oscClk)
    begin
        if (rstOsc)
            reqSync_reg <= 3'h0;
        else
            reqSync_reg <= {reqSync_reg[1:0], reqTgl_reg};
    end
    assign newReq = reqSync_reg[1] ^ reqSync_reg[2];

    // Capture the new trim, then answer with the ack toggle
    always_ff @(posedge oscClk)
    begin
        if (rstOsc)
        begin
            pendTrim_reg <= `TRIM_RESET;
            ackTgl_reg <= 1'b0;
        end
        else if (newReq)
        begin
            pendTrim_reg <= trim_reg;
            ackTgl_reg <= ~ackTgl_reg;
        end
    end

    // Interval length and step are taken from the active copy only
    assign intervalLen = activeTrim_reg[`TRIM_RES_BIT] ? `INTERVAL_FINE
        : `INTERVAL_COARSE;
    assign corrSecond = secCnt_reg == (intervalLen - `SEC_ONE);
    assign steps = decodeSteps(activeTrim_reg);
    // Two oscillator cycles per step, positive count shortens the second
    assign adjust = {{(`OSC_COUNT_W-8){steps[6]}}, steps, 1'b0};
    assign periodLen = corrSecond ? DIV_CYCLES - adjust : DIV_CYCLES;
    assign secondEnd = subCnt_reg == (periodLen - `OSC_SUB_ONE);
    assign boundary = secondEnd && corrSecond;

    // Divider chain; the oscillator itself runs untouched
    always_ff @(posedge oscClk)
    begin
        if (rstOsc)
            subCnt_reg <= `OSC_SUB_ZERO;
        else if (secondEnd)
            subCnt_reg <= `OSC_SUB_ZERO;
        else
            subCnt_reg <= subCnt_reg + `OSC_SUB_ONE;
    end

    // Seconds within the correction interval
    always_ff @(posedge oscClk)
    begin
        if (rstOsc)
            secCnt_reg <= `SEC_ZERO;
        else if (boundary)
            secCnt_reg <= `SEC_ZERO;
        else if (secondEnd)
            secCnt_reg <= secCnt_reg + `SEC_ONE;
    end

    // Trim swap at boundary, so no interval mixes two settings
    always_ff @(posedge oscClk)
    begin
        if (rstOsc)
            activeTrim_reg <= `TRIM_RESET;
        else if (boundary)
            activeTrim_reg <= pendTrim_reg;
    end

    // 1 Hz output: only the low half absorbs the correction
    always_ff @(posedge oscClk)
    begin
        if (rstOsc)
        begin
            tick_reg <= 1'b0;
            corrActive_reg <= 1'b0;
        end
        else
        begin
            tick_reg <= subCnt_reg < HALF_CYCLES;
            corrActive_reg <= steps != 7'h00;
        end
    end

    assign tick1Hz = tick_reg;

    a_trim_stable: assert property (@(posedge oscClk) disable iff (rstOsc)
        !boundary |=> $stable(activeTrim_reg))
        else $error("trim changed inside an interval");
    a_nominal_second: assert property (@(posedge oscClk) disable iff (rstOsc)
        (secondEnd && !corrSecond) |-> subCnt_reg == DIV_CYCLES - `OSC_SUB_ONE)
        else $error("uncorrected second has wrong length");
    a_corrected_second: assert property (@(posedge oscClk) disable iff (rstOsc)
        boundary |-> subCnt_reg + `OSC_SUB_ONE + adjust == DIV_CYCLES)
        else $error("corrected second length wrong");
    a_fine_interval: assert property (@(posedge oscClk) disable iff (rstOsc)
        (secondEnd && activeTrim_reg[`TRIM_RES_BIT] && secCnt_reg == `INTERVAL_FINE - `SEC_ONE)
        |=> secCnt_reg == `SEC_ZERO)
        else $error("60 s interval did not wrap");
    a_coarse_interval: assert property (@(posedge oscClk) disable iff (rstOsc)
        (secondEnd && !activeTrim_reg[`TRIM_RES_BIT]
        && secCnt_reg == `INTERVAL_COARSE - `SEC_ONE) |=> secCnt_reg == `SEC_ZERO)
        else $error("20 s interval did not wrap");
    a_trim_store: assert property (@(posedge clk) disable iff (rst)
        link.valid |=> trim_reg == $past(link.data) && busy)
        else $error("byte not stored or busy not raised");

endmodule

// [two_wire_host.sv]
`timescale 1ns/10ps
module two_wire_host (
    // Timing reference
    input wire logic clk,
    // Bus wires, sda resolved by the bench
    input wire logic sdaLine,
    output logic scl,
    output logic sdaLow
);
    // Idle bus: both lines released
    initial
    begin
        scl = 1'b1;
        sdaLow = 1'b0;
    end

    // Half SCL period, well above the receiver's two-stage sync delay
    task automatic half();
        repeat (6) @(negedge clk);
    endtask

    // Short hold after SCL falls so SDA never moves in the same step
    task automatic hold();
        repeat (2) @(negedge clk);
    endtask

    // Works from idle or mid-byte: SDA released under low SCL first
    task automatic startCond();
        scl = 1'b0;
        hold();
        sdaLow = 1'b0;
        half();
        scl = 1'b1;
        half();
        sdaLow = 1'b1;
        half();
        scl = 1'b0;
    endtask

    // SDA rises under high SCL
    task automatic stopCond();
        hold();
        sdaLow = 1'b1;
        half();
        scl = 1'b1;
        half();
        sdaLow = 1'b0;
        half();
    endtask

    // Data only changes while SCL is low
    task automatic sendBit(input logic b);
        hold();
        sdaLow = !b;
        half();
        scl = 1'b1;
        half();
        scl = 1'b0;
    endtask

    // MSB first, then a ninth clock with SDA released
    task automatic writeByte(input logic [7:0] d, output logic ack);
        for (int i = 7; i >= 0; i--)
            sendBit(d[i]);
        hold();
        sdaLow = 1'b0;
        half();
        scl = 1'b1;
        half();
        ack = !sdaLine;
        scl = 1'b0;
    endtask
endmodule

// [rtc_clock_rate_correction_bench.sv]
`timescale 1ns/10ps
module rtc_clock_rate_correction_bench;
    // Short second keeps 60 s intervals inside the run budget
    localparam int OSC_DIV_SIM = 260;

    typedef struct {logic [7:0] data; logic [7:0] trimExp;} row_type;

    logic clk;
    logic oscClk;
    logic rst;
    logic scl;
    logic sdaLow;
    logic sdaLine;
    logic sdaOut;
    logic sdaOe;
    logic [7:0] trimValue;
    logic correctionOn;
    logic tick1Hz;
    logic ack;
    logic tickPrev = 1'b0;
    int oscCount = 0;
    int periods[$];
    int n_mismatch = 0;
    int check_count = 0;
    row_type rows [6] = '{'{8'h00, 8'h00}, '{8'hff, 8'hff}, '{8'h01, 8'h01},
        '{8'h80, 8'h80}, '{8'ha5, 8'ha5}, '{8'h5a, 8'h5a}};

    // Open-drain wire with pull-up
    assign sdaLine = !(sdaLow || (sdaOe && !sdaOut));

    // Clocks, unrelated in phase
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial
    begin
        oscClk = 1'b0;
        #13;
        forever #40 oscClk = ~oscClk;
    end

    rtc_clock_rate_correction #(.OSC_DIV(OSC_DIV_SIM)) uut (
        .clk(clk),
        .rst(rst),
        .oscClk(oscClk),
        .scl(scl),
        .sdaIn(sdaLine),
        .sdaOut(sdaOut),
        .sdaOe(sdaOe),
        .trimValue(trimValue),
        .correctionOn(correctionOn),
        .tick1Hz(tick1Hz)
    );

    two_wire_host host (
        .clk(clk),
        .sdaLine(sdaLine),
        .scl(scl),
        .sdaLow(sdaLow)
    );

    // Second lengths in oscillator cycles, rise to rise; sampled off the launching edge
    always @(negedge oscClk)
    begin
        tickPrev <= tick1Hz;
        oscCount <= oscCount + 1;
        if (tick1Hz === 1'b1 && tickPrev === 1'b0)
        begin
            periods.push_back(oscCount);
            oscCount <= 1;
        end
    end

    task automatic wrap_up();
        if (n_mismatch == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] expected);
        check_count++;
        if (seen !== expected)
        begin
            n_mismatch++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, expected);
        end
    endtask

    // Whole access: start, one byte, stop
    task automatic access(input logic [7:0] d, output logic a);
        host.startCond();
        host.writeByte(d, a);
        host.stopCond();
    endtask

    // Bounded wait for a number of measured seconds
    task automatic waitPeriods(input int n);
        int k = 0;
        while (periods.size() < n && k < n * 600)
        begin
            @(negedge clk);
            k++;
        end
        if (periods.size() < n)
        begin
            n_mismatch++;
            wrap_up();
        end
    endtask

    // Reversed signed count, bit one as its sign; two cycles per step
    function automatic int alteredLen(input logic [7:0] t);
        logic [6:0] v;
        for (int i = 0; i < 7; i++)
            v[6 - i] = t[1 + i];
        return OSC_DIV_SIM - 2 * int'($signed(v));
    endfunction

    // Off-nominal seconds sit one interval apart; the first may still carry the old trim
    task automatic checkPeriods(input logic [7:0] tOld, input logic [7:0] t,
        input int interval);
        int last = -1;
        int hits = 0;
        foreach (periods[i])
        begin
            if (periods[i] != OSC_DIV_SIM)
            begin
                check(16'(periods[i]), 16'(alteredLen(hits == 0 ? tOld : t)));
                if (last >= 0)
                    check(16'(i - last), 16'(interval));
                last = i;
                hits++;
            end
        end
        check(16'(hits), 16'h0002);
    endtask

    initial
    begin
        rst = 1'b1;
        repeat (16) @(negedge clk);
        rst = 1'b0;
        repeat (8) @(negedge clk);
        check(16'(trimValue), 16'h0000);
        check(16'(correctionOn), 16'h0000);
        check(16'(sdaOe), 16'h0000);
        // Ordinary single-byte writes
        foreach (rows[i])
        begin
            access(rows[i].data, ack);
            check(16'(ack), 16'h0001);
            check(16'(trimValue), 16'(rows[i].trimExp));
        end
        // Stop in mid-byte drops the partial byte
        host.startCond();
        host.writeByte(8'h33, ack);
        for (int i = 0; i < 4; i++)
            host.sendBit(1'b0);
        host.stopCond();
        check(16'(trimValue), 16'h0033);
        // Repeated start in mid-byte, then two whole bytes
        host.startCond();
        for (int i = 0; i < 3; i++)
            host.sendBit(1'b1);
        host.startCond();
        host.writeByte(8'h6e, ack);
        check(16'(ack), 16'h0001);
        check(16'(trimValue), 16'h006e);
        host.writeByte(8'h42, ack);
        host.stopCond();
        check(16'(trimValue), 16'h0042);
        // Clocking without a start is ignored and not acknowledged
        host.writeByte(8'h99, ack);
        check(16'(ack), 16'h0000);
        check(16'(trimValue), 16'h0042);
        host.stopCond();
        // Still inside the first interval, nothing active yet
        check(16'(correctionOn), 16'h0000);
        // Reset in mid-run clears the trim and restarts the interval count
        rst = 1'b1;
        repeat (16) @(negedge clk);
        rst = 1'b0;
        repeat (8) @(negedge clk);
        check(16'(trimValue), 16'h0000);
        check(16'(correctionOn), 16'h0000);
        check(16'(sdaOe), 16'h0000);
        // Fast clock: 128 - 22 = 106, coarse step; hits at seconds 39 and 59
        access(8'h56, ack);
        check(16'(ack), 16'h0001);
        periods.delete();
        waitPeriods(60);
        checkPeriods(8'h56, 8'h56, 20);
        check(16'(correctionOn), 16'h0001);
        // Slow clock: 26 + 1 = 27 at fine step; old trim still ends its interval
        access(8'hd9, ack);
        check(16'(ack), 16'h0001);
        periods.delete();
        waitPeriods(81);
        checkPeriods(8'h56, 8'hd9, 60);
        wrap_up();
    end
endmodule
